//--- rtl/scabe_defines.vh
// constants for the add, logic and branch execute block
`ifndef SCABE_DEFINES_VH
`define SCABE_DEFINES_VH
// instruction fields, bit 0 of the printed layout is word bit 31
`define SCABE_OP_HI       31
`define SCABE_OP_LO       26
`define SCABE_RD_HI       25
`define SCABE_RD_LO       21
`define SCABE_RA_HI       20
`define SCABE_RA_LO       16
`define SCABE_RB_HI       15
`define SCABE_RB_LO       11
`define SCABE_IMM_HI      15
`define SCABE_IMM_LO      0
`define SCABE_KEEP_BIT    28
`define SCABE_CIN_BIT     27
`define SCABE_DLY_BIT     25
`define SCABE_IMMSEL_BIT  29
`define SCABE_COND_HI     24
`define SCABE_COND_LO     21
`define SCABE_FAM_HI      31
`define SCABE_FAM_LO      30
`define SCABE_FAM_ZBIT    26
// encodings
`define SCABE_FAM_ADD     2'h0
`define SCABE_COND_EQ     4'h0
`define SCABE_OP_AND      6'h21
`define SCABE_OP_ANDN     6'h23
`define SCABE_OP_ANDI     6'h29
`define SCABE_OP_ANDNI    6'h2b
`define SCABE_OP_BRREG    6'h27
// program counter
`define SCABE_PC_STEP     32'h0000_0004
`define SCABE_PC_RESET    32'h0000_0000
// register map, byte addresses
`define SCABE_REG_CTRL    8'h00
`define SCABE_REG_STATUS  8'h04
`define SCABE_REG_PC      8'h08
`define SCABE_REG_RFIDX   8'h0c
`define SCABE_REG_RFDATA  8'h10
// register fields
`define SCABE_CTRL_RUN    0
`define SCABE_ST_CARRY    0
`define SCABE_ST_ILL      1
`define SCABE_ST_BUSY     2
`endif

//--- rtl/scabe_alu.v
// decode and combinational execute of the add, logic and branch subset
`timescale 1ns/10ps
`include "scabe_defines.vh"
module scabe_alu (
    // instruction and wide immediate prefix
    input  wire [31:0] instrWord,
    input  wire        wideImmValid,
    input  wire [15:0] wideImmHi,
    // operands
    input  wire [31:0] opA,
    input  wire [31:0] opB,
    input  wire        carryFlag,
    // results
    output reg  [31:0] result,
    output reg         rdWrite,
    output reg         carryWrite,
    output wire        carryOut,
    output reg         isBranch,
    output reg         illegal
);
    wire [5:0]  opcode = instrWord[`SCABE_OP_HI:`SCABE_OP_LO];
    wire [15:0] immFld = instrWord[`SCABE_IMM_HI:`SCABE_IMM_LO];
    // prefix replaces the sign extension with a full word
    wire [31:0] immOp  = wideImmValid ? {wideImmHi, immFld}
                                      : {{16{immFld[15]}}, immFld};
    wire        useImm = instrWord[`SCABE_IMMSEL_BIT];
    wire [31:0] opnd   = useImm ? immOp : opB;
    // option bit only selects; the flag value comes from the status copy
    wire        cin    = instrWord[`SCABE_CIN_BIT] & carryFlag;
    wire [32:0] sum    = {1'b0, opA} + {1'b0, opnd} + {32'h0, cin};
    wire        isAdd  = (instrWord[`SCABE_FAM_HI:`SCABE_FAM_LO] == `SCABE_FAM_ADD)
                         && !instrWord[`SCABE_FAM_ZBIT];

    assign carryOut = sum[32];

    // decode; anything outside the subset is flagged and retires as no-op
    always @* begin
        result     = 32'h0;
        rdWrite    = 1'b0;
        carryWrite = 1'b0;
        isBranch   = 1'b0;
        illegal    = 1'b0;
        if (isAdd) begin
            result     = sum[31:0];
            rdWrite    = 1'b1;
            carryWrite = !instrWord[`SCABE_KEEP_BIT];
        end else begin
            case (opcode)
                `SCABE_OP_AND, `SCABE_OP_ANDI: begin
                    result  = opA & opnd;
                    rdWrite = 1'b1;
                end
                `SCABE_OP_ANDN, `SCABE_OP_ANDNI: begin
                    result  = opA & ~opnd;
                    rdWrite = 1'b1;
                end
                `SCABE_OP_BRREG: begin
                    if (instrWord[`SCABE_COND_HI:`SCABE_COND_LO] == `SCABE_COND_EQ)
                        isBranch = 1'b1;
                    else
                        illegal = 1'b1;
                end
                default: illegal = 1'b1;
            endcase
        end
    end
endmodule // scabe_alu

//--- rtl/scabe_top.v
// execute stage for add, logic and register branch, with apb access
//
// Functional notes
// - reg-reg fields: opcode, dest at 6, sources 11, 16
// - reg-imm: opcode, dest, source, imm bits 16-31
// - add writes sum of both sources
// - keep bit 3 holds carry, else takes carry-out
// - carry-in bit 4 adds current carry flag
// - carry-in option bit never aliases the flag
// - add immediate sign-extends sixteen bits, same options
// - wide prefix supplies full 32-bit immediate
// - and writes bitwise and of sources
// - and-immediate uses sign-extended immediate
// - and-not ands first with complemented second
// - and-not-immediate complements sign-extended immediate
// - branch when first source zero to pc+second
// - not taken advances pc by four
// - delay bit lets following instruction complete
// - no delay bit squashes following instruction
// - branch takes 1, 2 or 3 cycles
`timescale 1ns/10ps
`include "scabe_defines.vh"
module scabe_top #(
    parameter NUM_REGS = 32,
    parameter REG_AW   = 5,
    parameter ADDR_W   = 8
) (
    // clock and reset
    input  wire              core_clk,
    input  wire              arst_n,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output reg               pslverr,
    // instruction fetch side
    output reg  [31:0]       fetchPc,
    input  wire              instrValid,
    input  wire [31:0]       instrWord,
    output wire              instrReady,
    input  wire              wideImmValid,
    input  wire [15:0]       wideImmHi,
    output reg               squash,
    // status
    output reg               carryFlag
);
    // one-hot sequencer states
    localparam [3:0] S_HALT = 4'b0001;
    localparam [3:0] S_EXEC = 4'b0010;
    localparam [3:0] S_BUB2 = 4'b0100;
    localparam [3:0] S_BUB1 = 4'b1000;

    // reset release through two flops
    reg  [1:0]  rstSync_r;
    wire        rstN = rstSync_r[1];

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            rstSync_r <= 2'b00;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end

    // state and storage
    reg  [3:0]        state_r;
    reg  [3:0]        state_nxt;
    reg  [31:0]       fetchPc_nxt;
    reg  [31:0]       pendTgt_r;
    reg  [31:0]       pendTgt_nxt;
    reg               pendValid_r;
    reg               pendValid_nxt;
    reg               squash_nxt;
    reg               run_r;
    reg               illegal_r;
    reg  [REG_AW-1:0] rfIdx_r;
    reg  [31:0]       gpr_r [0:NUM_REGS-1];

    // field extraction
    wire [REG_AW-1:0] rdIdx = instrWord[`SCABE_RD_HI:`SCABE_RD_LO];
    wire [REG_AW-1:0] raIdx = instrWord[`SCABE_RA_HI:`SCABE_RA_LO];
    wire [REG_AW-1:0] rbIdx = instrWord[`SCABE_RB_HI:`SCABE_RB_LO];
    wire [31:0]       opA   = gpr_r[raIdx];
    wire [31:0]       opB   = gpr_r[rbIdx];

    wire [31:0] aluResult;
    wire        aluRdWr;
    wire        aluCarryWr;
    wire        aluCarryOut;
    wire        aluBranch;
    wire        aluIllegal;

    scabe_alu u_alu (
        .instrWord    (instrWord),
        .wideImmValid (wideImmValid),
        .wideImmHi    (wideImmHi),
        .opA          (opA),
        .opB          (opB),
        .carryFlag    (carryFlag),
        .result       (aluResult),
        .rdWrite      (aluRdWr),
        .carryWrite   (aluCarryWr),
        .carryOut     (aluCarryOut),
        .isBranch     (aluBranch),
        .illegal      (aluIllegal)
    );

    // handshake with fetch; bubbles hold the fetcher off
    assign instrReady = (state_r == S_EXEC);
    wire   accept     = instrValid && instrReady;
    wire   exeWr      = accept && aluRdWr;
    wire   taken      = accept && aluBranch && (opA == 32'h0);
    // base is the address the branch itself was fetched from
    wire [31:0] target  = fetchPc + opB;
    wire [31:0] seqPc   = fetchPc + `SCABE_PC_STEP;

    // apb decode
    wire        apbSetup  = psel && !penable;
    wire        apbWr     = psel && penable && pwrite;
    wire        halted    = (state_r == S_HALT);
    wire        hitCtrl   = (paddr == `SCABE_REG_CTRL);
    wire        hitStatus = (paddr == `SCABE_REG_STATUS);
    wire        hitPc     = (paddr == `SCABE_REG_PC);
    wire        hitIdx    = (paddr == `SCABE_REG_RFIDX);
    wire        hitData   = (paddr == `SCABE_REG_RFDATA);
    wire        hitAny    = hitCtrl | hitStatus | hitPc | hitIdx | hitData;
    // program state only changes while stopped, so no race with execution
    wire        apbGprWr  = apbWr && hitData && halted;
    wire        apbPcWr   = apbWr && hitPc && halted;

    assign pready = psel && penable;

    // sequencer: branch cost is the accept cycle plus the bubbles
    always @* begin
        state_nxt     = state_r;
        fetchPc_nxt   = fetchPc;
        pendTgt_nxt   = pendTgt_r;
        pendValid_nxt = pendValid_r;
        squash_nxt    = 1'b0;
        case (state_r)
            S_HALT: begin
                if (apbPcWr) begin
                    fetchPc_nxt   = pwdata;
                    pendValid_nxt = 1'b0;
                end
                if (run_r)
                    state_nxt = S_EXEC;
            end
            S_EXEC: begin
                if (taken && instrWord[`SCABE_DLY_BIT]) begin
                    // slot instruction runs next, target after it
                    fetchPc_nxt   = seqPc;
                    pendTgt_nxt   = target;
                    pendValid_nxt = 1'b1;
                    state_nxt     = S_BUB1;
                end else if (taken) begin
                    // prefetched successor must be thrown away
                    fetchPc_nxt   = target;
                    pendValid_nxt = 1'b0;
                    squash_nxt    = 1'b1;
                    state_nxt     = S_BUB2;
                end else if (accept) begin
                    if (pendValid_r) begin
                        fetchPc_nxt   = pendTgt_r;
                        pendValid_nxt = 1'b0;
                    end else begin
                        fetchPc_nxt   = seqPc;
                    end
                    if (!run_r)
                        state_nxt = S_HALT;
                end else if (!run_r) begin
                    state_nxt = S_HALT;
                end
            end
            S_BUB2:  state_nxt = S_BUB1;
            S_BUB1:  state_nxt = S_EXEC;
            default: state_nxt = S_HALT;
        endcase
    end

    // sequencer registers
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state_r     <= S_HALT;
            fetchPc     <= `SCABE_PC_RESET;
            pendTgt_r   <= `SCABE_PC_RESET;
            pendValid_r <= 1'b0;
            squash      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            fetchPc     <= fetchPc_nxt;
            pendTgt_r   <= pendTgt_nxt;
            pendValid_r <= pendValid_nxt;
            squash      <= squash_nxt;
        end
    end

    // carry flag; execution owns it, software may preset it while stopped
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN)
            carryFlag <= 1'b0;
        else if (accept && aluCarryWr)
            carryFlag <= aluCarryOut;
        else if (apbWr && hitStatus && halted)
            carryFlag <= pwdata[`SCABE_ST_CARRY];
    end

    // control and sticky illegal flag, a new event beats the clear
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            run_r     <= 1'b0;
            illegal_r <= 1'b0;
            rfIdx_r   <= {REG_AW{1'b0}};
        end else begin
            if (apbWr && hitCtrl)
                run_r <= pwdata[`SCABE_CTRL_RUN];
            if (apbWr && hitIdx)
                rfIdx_r <= pwdata[REG_AW-1:0];
            if (accept && aluIllegal)
                illegal_r <= 1'b1;
            else if (apbWr && hitStatus && pwdata[`SCABE_ST_ILL])
                illegal_r <= 1'b0;
        end
    end

    // general registers, one writer process per entry
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_gpr
            localparam integer IDX = gi;
            always @(posedge core_clk or negedge rstN) begin
                if (!rstN)
                    gpr_r[gi] <= 32'h0;
                else if (exeWr && (rdIdx == IDX[REG_AW-1:0]))
                    gpr_r[gi] <= aluResult;
                else if (apbGprWr && (rfIdx_r == IDX[REG_AW-1:0]))
                    gpr_r[gi] <= pwdata;
            end
        end
    endgenerate

    // read data captured in the setup cycle, held through the access phase
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (apbSetup) begin
            pslverr <= !hitAny;
            prdata  <= 32'h0;
            if (!pwrite) begin
                if (hitCtrl)
                    prdata[`SCABE_CTRL_RUN] <= run_r;
                if (hitStatus) begin
                    prdata[`SCABE_ST_CARRY] <= carryFlag;
                    prdata[`SCABE_ST_ILL]   <= illegal_r;
                    prdata[`SCABE_ST_BUSY]  <= !halted;
                end
                if (hitPc)
                    prdata <= fetchPc;
                if (hitIdx)
                    prdata[REG_AW-1:0] <= rfIdx_r;
                if (hitData)
                    prdata <= gpr_r[rfIdx_r];
            end
        end
    end
endmodule // scabe_top

//--- sim/scabe_top_sva.sv
// assertion checker for the add, logic and branch execute block
`timescale 1ns/10ps
`include "scabe_defines.vh"
module scabe_top_sva #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input wire              core_clk,
    input wire              arst_n,
    // apb
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire              pready,
    input wire [31:0]       prdata,
    input wire              pslverr,
    // fetch side and status
    input wire [31:0]       fetchPc,
    input wire              instrValid,
    input wire [31:0]       instrWord,
    input wire              instrReady,
    input wire              wideImmValid,
    input wire [15:0]       wideImmHi,
    input wire              squash,
    input wire              carryFlag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // decode of the word being taken
    wire take  = instrValid & instrReady;
    wire isBr  = instrWord[31:26] == `SCABE_OP_BRREG && instrWord[24:21] == `SCABE_COND_EQ;
    wire isAdd = instrWord[31:30] == `SCABE_FAM_ADD && !instrWord[26];
    wire isLog = instrWord[31:30] == 2'h2 && instrWord[26] && !instrWord[28];
    // branch aftermath; operands are not visible here, so ready tells taken-with-slot
    reg        brAcc_r;
    reg        brD_r;
    reg        slotPend_r;
    reg [31:0] brPc_r;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            brAcc_r    <= 1'b0;
            brD_r      <= 1'b0;
            slotPend_r <= 1'b0;
            brPc_r     <= 32'h0;
        end else begin
            brAcc_r    <= take & isBr;
            brD_r      <= instrWord[`SCABE_DLY_BIT];
            brPc_r     <= fetchPc;
            slotPend_r <= (brAcc_r & !squash & !instrReady) | (slotPend_r & !take);
        end
    end
    a_apb_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (psel && penable && paddr > `SCABE_REG_RFDATA |-> pslverr)
        else $error("no error on unmapped address");
    a_seq_step: assert property (
        take && !isBr && !slotPend_r |=> fetchPc == $past(fetchPc) + `SCABE_PC_STEP)
        else $error("pc did not step by four");
    a_branch_next: assert property (
        brAcc_r && !squash |-> fetchPc == brPc_r + `SCABE_PC_STEP)
        else $error("pc after branch not branch address plus four");
    a_untaken_one: assert property (brAcc_r && !brD_r && !squash |-> instrReady)
        else $error("untaken branch stalled");
    a_squash_window: assert property (
        $rose(squash) |-> !instrReady ##1 (!instrReady && !squash) ##1 instrReady)
        else $error("taken branch without slot not three cycles");
    a_squash_cause: assert property (squash |-> brAcc_r && !brD_r)
        else $error("squash without taken branch lacking slot");
    a_slot_window: assert property (
        brAcc_r && brD_r && !instrReady |-> !squash ##1 instrReady)
        else $error("slot branch not two cycles");
    a_keep_carry: assert property (
        take && isAdd && instrWord[`SCABE_KEEP_BIT] |=> $stable(carryFlag))
        else $error("keep option changed carry");
    a_logic_carry: assert property (take && isLog |=> $stable(carryFlag))
        else $error("logic op changed carry");
    a_branch_carry: assert property (take && isBr |=> $stable(carryFlag))
        else $error("branch changed carry");
endmodule // scabe_top_sva

//--- sim/soft_core_add_logic_branch_exec_test.sv
// self-checking testbench for the add, logic and branch execute block
`timescale 1ns/10ps
`include "scabe_defines.vh"
module soft_core_add_logic_branch_exec_test;
    // clock, reset and apb
    reg         core_clk;
    reg         arst_n;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata;
    wire        pready;
    wire [31:0] prdata;
    wire        pslverr;
    // fetch side
    wire [31:0] fetchPc;
    reg         instrValid;
    reg  [31:0] instrWord;
    wire        instrReady;
    reg         wideImmValid;
    reg  [15:0] wideImmHi;
    wire        squash;
    wire        carryFlag;
    // bench state
    integer     mismatches;
    integer     n_checks;
    integer     cycles = 0;
    integer     i;
    reg  [31:0] expPc;
    reg         expC;
    reg  [31:0] rdata;
    reg         err;
    reg  [31:0] gpr [0:31];

    scabe_top dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .fetchPc(fetchPc), .instrValid(instrValid),
        .instrWord(instrWord), .instrReady(instrReady), .wideImmValid(wideImmValid),
        .wideImmHi(wideImmHi), .squash(squash), .carryFlag(carryFlag)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // hang guard, the run needs a few hundred cycles
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            final_report;
        end
    end

    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task cmp32(input [63:0] what, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // one apb transfer; request held until pready seen at an edge
    task apb(input wr, input [7:0] a, input [31:0] d);
        begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            // only the hang guard ends this wait
            while (pready !== 1'b1)
                @(posedge core_clk);
            rdata = prdata;
            err   = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    // present one word; valid stays up so the next call follows back to back
    task step(input [31:0] w, input wide, input newC);
        begin
            instrValid   <= 1'b1;
            instrWord    <= w;
            wideImmValid <= wide;
            wideImmHi    <= 16'h1234;
            @(negedge core_clk);
            while (instrReady !== 1'b1)
                @(negedge core_clk);
            cmp32("pc", expPc, fetchPc);
            cmp32("carry", {31'h0, expC}, {31'h0, carryFlag});
            @(posedge core_clk);
            expPc = expPc + `SCABE_PC_STEP;
            expC  = newC;
        end
    endtask

    function [31:0] rr(input [5:0] op, input [4:0] d, input [4:0] a, input [4:0] b);
        rr = {op, d, a, b, 11'h000};
    endfunction

    function [31:0] ri(input [5:0] op, input [4:0] d, input [4:0] a, input [15:0] k);
        ri = {op, d, a, k};
    endfunction

    // main sequence
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        instrValid = 1'b0;
        instrWord = 32'h0;
        wideImmValid = 1'b0;
        wideImmHi = 16'h0;
        mismatches = 0;
        n_checks = 0;
        gpr[0] = 32'h0;
        gpr[1] = 32'hffff_ffff;
        gpr[2] = 32'h0000_0001;
        gpr[3] = 32'h0f0f_f0f0;
        gpr[4] = 32'h1234_5678;
        gpr[5] = 32'h0000_0010;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        // operands loaded while halted
        for (i = 0; i < 6; i = i + 1) begin
            apb(1'b1, `SCABE_REG_RFIDX, i);
            apb(1'b1, `SCABE_REG_RFDATA, gpr[i]);
        end
        apb(1'b1, `SCABE_REG_STATUS, 32'h0);
        apb(1'b1, `SCABE_REG_PC, 32'h0000_0100);
        apb(1'b1, `SCABE_REG_CTRL, 32'h0000_0001);
        expPc = 32'h0000_0100;
        expC = 1'b0;
        step(rr(6'h00, 7, 1, 2), 1'b0, 1'b1);
        step(rr(6'h02, 8, 2, 2), 1'b0, 1'b0);
        step(rr(6'h06, 9, 1, 2), 1'b0, 1'b0);
        step(rr(6'h00, 10, 1, 1), 1'b0, 1'b1);
        step(rr(6'h04, 11, 2, 2), 1'b0, 1'b1);
        step(rr(6'h06, 12, 2, 0), 1'b0, 1'b1);
        step(ri(6'h08, 13, 2, 16'hffff), 1'b0, 1'b1);
        step(ri(6'h0a, 14, 0, 16'h7fff), 1'b0, 1'b0);
        step(ri(6'h0c, 15, 0, 16'h5678), 1'b1, 1'b0);
        step(ri(6'h0e, 16, 1, 16'h0001), 1'b0, 1'b0);
        step(rr(`SCABE_OP_AND, 17, 3, 4), 1'b0, 1'b0);
        step(rr(`SCABE_OP_ANDN, 18, 3, 4), 1'b0, 1'b0);
        step(ri(`SCABE_OP_ANDI, 19, 4, 16'h8f00), 1'b0, 1'b0);
        step(ri(`SCABE_OP_ANDNI, 20, 4, 16'h8f00), 1'b0, 1'b0);
        step(rr(`SCABE_OP_BRREG, 0, 2, 5), 1'b0, 1'b0);
        step(rr(`SCABE_OP_BRREG, 0, 0, 5), 1'b0, 1'b0);
        @(negedge core_clk);
        cmp32("squash", 32'h1, {31'h0, squash});
        @(posedge core_clk);
        expPc = 32'h0000_013c + gpr[5];
        step(rr(`SCABE_OP_BRREG, 5'h10, 0, 5), 1'b0, 1'b0);
        @(negedge core_clk);
        cmp32("squash", 32'h0, {31'h0, squash});
        @(posedge core_clk);
        step(rr(6'h00, 21, 2, 2), 1'b0, 1'b0);
        expPc = 32'h0000_014c + gpr[5];
        step(rr(6'h04, 22, 4, 2), 1'b0, 1'b0);
        // unknown opcode retires as a no-op and marks status
        step(32'hfc00_0000, 1'b0, 1'b0);
        instrValid <= 1'b0;
        wideImmValid <= 1'b0;
        @(negedge core_clk);
        cmp32("pc", expPc, fetchPc);
        cmp32("carry", {31'h0, expC}, {31'h0, carryFlag});
        @(posedge core_clk);
        // status: illegal and busy set, carry clear; write one clears illegal
        apb(1'b0, `SCABE_REG_STATUS, 32'h0);
        cmp32("status", 32'h6, rdata);
        apb(1'b1, `SCABE_REG_STATUS, 32'h2);
        apb(1'b0, `SCABE_REG_STATUS, 32'h0);
        cmp32("status", 32'h4, rdata);
        apb(1'b0, `SCABE_REG_PC, 32'h0);
        cmp32("pcreg", expPc, rdata);
        // results worked out from the operands
        gpr[7] = gpr[1] + gpr[2];
        gpr[8] = gpr[2] + gpr[2] + 32'h1;
        gpr[9] = gpr[1] + gpr[2];
        gpr[10] = gpr[1] + gpr[1];
        gpr[11] = gpr[2] + gpr[2];
        gpr[12] = gpr[2] + 32'h1;
        gpr[13] = gpr[2] + 32'hffff_ffff;
        gpr[14] = 32'h0000_7fff + 32'h1;
        gpr[15] = 32'h1234_5678;
        gpr[16] = gpr[1] + 32'h1;
        gpr[17] = gpr[3] & gpr[4];
        gpr[18] = gpr[3] & ~gpr[4];
        gpr[19] = gpr[4] & 32'hffff_8f00;
        gpr[20] = gpr[4] & ~32'hffff_8f00;
        gpr[21] = gpr[2] + gpr[2];
        gpr[22] = gpr[4] + gpr[2];
        for (i = 7; i < 23; i = i + 1) begin
            apb(1'b1, `SCABE_REG_RFIDX, i);
            apb(1'b0, `SCABE_REG_RFDATA, 32'h0);
            cmp32("gpr", gpr[i], rdata);
        end
        // unmapped place must answer with an error
        apb(1'b0, 8'h20, 32'h0);
        cmp32("slverr", 32'h1, {31'h0, err});
        final_report;
    end
endmodule // soft_core_add_logic_branch_exec_test

bind scabe_top scabe_top_sva #(.ADDR_W(ADDR_W)) chk_u (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .fetchPc(fetchPc), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .wideImmValid(wideImmValid),
    .wideImmHi(wideImmHi), .squash(squash), .carryFlag(carryFlag)
);
